// ===== design/gpib_status_poll_logic.sv
// status byte, service request, serial and parallel poll logic
`timescale 1ns/100ps
`include "status_poll_defines.svh"
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////
module gpib_status_poll_logic
  import status_poll_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // bus pins from outside the clock domain
  input wire logic ifc_pin_in,
  input wire logic ppoll_pin_in,
  input wire logic standby_switch_position_in,
  // decoded bus commands, one-cycle pulses, and the poll configure field
  input wire logic spe_cmd_in,
  input wire logic spd_cmd_in,
  input wire logic untalk_cmd_in,
  input wire logic unlisten_cmd_in,
  input wire logic talk_addr_in,
  input wire logic listen_addr_in,
  input wire logic ppc_cmd_in,
  input wire logic [3:0] ppc_data_in,
  input wire logic ppu_cmd_in,
  input wire logic byte_taken_in,
  // instrument side
  input wire logic [7:0] cond_evt_in,
  input wire logic [7:0] ext_cond_in,
  input wire logic mask_wr_in,
  input wire logic [7:0] mask_data_in,
  input wire logic clear_status_in,
  input wire logic output_status_in,
  // service request line, open drain
  output logic srq_out,
  output logic srq_oe_out,
  // data lines, open drain
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe_out,
  // state and readouts
  output logic talker_out,
  output logic listener_out,
  output logic [7:0] ext_byte_out,
  output logic [7:0] mask_out
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  logic [2:0] ifc_sync_r; // ifc stages
  logic [2:0] pp_sync_r; // parallel poll stages
  logic [2:0] sb_sync_r; // standby stages
  logic ifc_r; // filtered abort level
  logic pp_r; // filtered parallel poll level
  logic sb_r; // filtered standby level
  // shift the stages; only stage 2 reads stage 1
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ifc_sync_r <= 3'h0;
      pp_sync_r <= 3'h0;
      sb_sync_r <= 3'h0;
    end else begin
      ifc_sync_r <= {ifc_sync_r[1:0], ifc_pin_in};
      pp_sync_r <= {pp_sync_r[1:0], ppoll_pin_in};
      sb_sync_r <= {sb_sync_r[1:0], standby_switch_position_in};
    end
  end
  // accept a new level only once stages 2 and 3 agree
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ifc_r <= 1'b0;
      pp_r <= 1'b0;
      sb_r <= 1'b0;
    end else begin
      if (ifc_sync_r[1] == ifc_sync_r[2]) ifc_r <= ifc_sync_r[2];
      if (pp_sync_r[1] == pp_sync_r[2]) pp_r <= pp_sync_r[2];
      if (sb_sync_r[1] == sb_sync_r[2]) sb_r <= sb_sync_r[2];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] mask_r; // request mask
  logic [7:0] stb_r; // status byte, rqs position kept zero
  logic [7:0] pend_r; // conditions that came while frozen
  logic [7:0] ext_r; // extended conditions seen last cycle
  logic srq_r; // service request asserted
  logic talk_r; // addressed as talker
  logic listen_r; // addressed as listener
  sp_state_t sp_r; // serial poll progress
  ppoll_cfg_t ppc_r; // parallel poll assignment
  ////////////////////////////////////////////////////////////////////
  // decode
  wire [7:0] ext_live = ext_cond_in & `EXT_LIVE_MASK;
  wire ext_change = (ext_live != ext_r); // sets weight 4
  wire [7:0] evt_all = (cond_evt_in & `STB_COND_MASK) |
                       ({7'h00, ext_change} << `STB_EXT_BIT);
  // only masked conditions may raise the summary bit
  wire rqs = |(stb_r & mask_r & `STB_COND_MASK);
  // byte seen on the bus: summary bit from the live request
  wire [7:0] stb_view = stb_r | ({7'h00, srq_r} << `STB_RQS_BIT);
  wire wipe = clear_status_in | output_status_in;
  // end of a poll that already delivered the byte
  wire poll_done = (sp_r == SP_SENT) &
                   (spd_cmd_in | ifc_r | untalk_cmd_in);
  wire sending = talk_r & (sp_r != SP_IDLE);
  // parallel poll status bit: true sense while requesting service
  wire ist_match = (srq_r == ppc_r.sense);
  wire pp_drive = pp_r & ppc_r.valid & ist_match;
  wire ppc_drop = ppu_cmd_in | sb_r;
  ////////////////////////////////////////////////////////////////////
  // next values of the status byte and the pending buffer
  logic [7:0] stb_nxt;
  logic [7:0] pend_nxt;
  always_comb begin
    stb_nxt = stb_r;
    pend_nxt = pend_r;
    if (wipe) begin
      // clear whether or not the byte was polled
      stb_nxt = `STB_RESET;
      pend_nxt = 8'h00;
    end else if (poll_done) begin
      // waiting bits move up; srq follows them back
      stb_nxt = pend_r | (evt_all & mask_r);
      pend_nxt = 8'h00;
    end else if (srq_r) begin
      // frozen: enabled arrivals wait, others are dropped
      pend_nxt = pend_r | (evt_all & mask_r);
    end else begin
      stb_nxt = stb_r | evt_all;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // status byte, pending buffer, service request
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stb_r <= `STB_RESET;
      pend_r <= 8'h00;
      srq_r <= 1'b0;
    end else begin
      stb_r <= stb_nxt;
      pend_r <= pend_nxt;
      // one cycle to release at poll end, even if bits are waiting; a clear releases it
      srq_r <= rqs & ~wipe & ~poll_done;
    end
  end
  // request mask and extended snapshot
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_r <= `MASK_RESET;
      ext_r <= 8'h00;
      ext_byte_out <= 8'h00;
    end else begin
      if (mask_wr_in) mask_r <= mask_data_in;
      ext_r <= ext_live;
      // extended byte leaves only through output-status
      if (output_status_in) ext_byte_out <= ext_live;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // addressing; abort wins over any address in the same cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      talk_r <= 1'b0;
      listen_r <= 1'b0;
    end else if (ifc_r) begin
      talk_r <= 1'b0;
      listen_r <= 1'b0;
    end else begin
      if (untalk_cmd_in) talk_r <= 1'b0;
      else if (talk_addr_in) talk_r <= 1'b1;
      if (unlisten_cmd_in) listen_r <= 1'b0;
      else if (listen_addr_in) listen_r <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // serial poll sequence
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sp_r <= SP_IDLE;
    end else begin
      case (sp_r)
        SP_IDLE: begin
          if (spe_cmd_in & ~ifc_r) sp_r <= SP_ARMED;
        end
        SP_ARMED: begin
          if (ifc_r | spd_cmd_in) sp_r <= SP_IDLE;
          else if (talk_r & byte_taken_in) sp_r <= SP_SENT;
        end
        SP_SENT: begin
          // an untalk, a disable or an abort ends the poll; without one srq stays until a clear or output status
          if (poll_done) sp_r <= SP_IDLE;
        end
        default: begin
          sp_r <= SP_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // parallel poll assignment
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ppc_r <= '0;
    end else if (ppc_drop) begin
      ppc_r <= '0;
    end else if (ppc_cmd_in) begin
      ppc_r.valid <= 1'b1;
      ppc_r.sense <= ppc_data_in[`PPC_SENSE_BIT];
      ppc_r.line <= ppc_data_in[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // pin drivers, all registered
  dio_drive_t dio_nxt;
  always_comb begin
    dio_nxt = '0;
    if (pp_drive) begin
      // one line only, no talker address needed
      dio_nxt.level[ppc_r.line] = 1'b1;
      dio_nxt.oe[ppc_r.line] = 1'b1;
    end else if (sending & ~ifc_r) begin
      dio_nxt.level = stb_view;
      dio_nxt.oe = 8'hff;
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dio_out <= 8'h00;
      dio_oe_out <= 8'h00;
      srq_out <= 1'b0;
      srq_oe_out <= 1'b0;
      talker_out <= 1'b0;
      listener_out <= 1'b0;
      mask_out <= `MASK_RESET;
    end else begin
      dio_out <= dio_nxt.level;
      dio_oe_out <= dio_nxt.oe;
      srq_out <= srq_r;
      srq_oe_out <= srq_r;
      talker_out <= talk_r;
      listener_out <= listen_r;
      mask_out <= mask_r;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence frozen_s;
    srq_r && !wipe && !poll_done;
  endsequence
  sequence done_s;
    poll_done && !wipe;
  endsequence
  stb_frozen_a: assert property (frozen_s |=> stb_r == $past(stb_r))
    else $error("status byte changed while srq asserted");
  // end of sweep is the bit that the bench really sends while frozen
  pend_hold_a: assert property (
    frozen_s ##0 (cond_evt_in[`STB_SWEEP_END_BIT] &&
    mask_r[`STB_SWEEP_END_BIT]) |=> pend_r[`STB_SWEEP_END_BIT])
    else $error("late enabled condition not buffered");
  pend_keep_a: assert property (done_s |=>
    stb_r == $past(pend_r | (evt_all & mask_r)))
    else $error("pending bits lost at poll end");
  wipe_all_a: assert property (wipe |=>
    stb_r == 8'h00 && pend_r == 8'h00 && !srq_r)
    else $error("clear status did not wipe");
  srq_rearm_a: assert property (done_s ##1 (rqs && !wipe) |=> srq_r)
    else $error("srq not reasserted for pending bits");
  srq_gate_a: assert property (srq_r |-> $past(|(stb_r & mask_r)))
    else $error("srq without masked condition");
  ifc_drop_a: assert property (ifc_r |=> !talk_r && !listen_r)
    else $error("abort left device addressed");
  pp_line_a: assert property (pp_drive |=>
    dio_oe_out == (8'h01 << $past(ppc_r.line)))
    else $error("parallel poll line wrong");
  ppc_clear_a: assert property (ppc_drop |=> !ppc_r.valid)
    else $error("poll assignment kept after unconfigure");
  ppc_store_a: assert property (ppc_cmd_in && !ppc_drop |=>
    ppc_r.valid && ppc_r.line == $past(ppc_data_in[2:0]) &&
    ppc_r.sense == $past(ppc_data_in[`PPC_SENSE_BIT]))
    else $error("poll configure not stored");
  ext_zero_a: assert property (
    ext_byte_out[7] == 1'b0 && ext_byte_out[2] == 1'b0)
    else $error("extended always-zero bit set");
  poll_send_a: assert property (sending && !ifc_r && !pp_drive |=>
    dio_out == $past(stb_view) && dio_oe_out == 8'hff)
    else $error("status byte not driven to talker");
endmodule // gpib_status_poll_logic

// ===== design/status_poll_defines.svh
// status poll block: offsets, field positions, reset values
`ifndef STATUS_POLL_DEFINES_SVH
`define STATUS_POLL_DEFINES_SVH
// status byte bit positions
`define STB_KEY_BIT 3'd0
`define STB_ENTRY_BIT 3'd1
`define STB_EXT_BIT 3'd2
`define STB_SETTLED_BIT 3'd3
`define STB_SWEEP_END_BIT 3'd4
`define STB_ERROR_BIT 3'd5
`define STB_RQS_BIT 3'd6
`define STB_SWEEP_PAR_BIT 3'd7
// bits of the status byte that conditions may set (all but rqs)
`define STB_COND_MASK 8'hbf
// extended byte: positions that carry a condition (4 and 128 are zero)
`define EXT_LIVE_MASK 8'h7b
// reset values
`define MASK_RESET 8'h00
`define STB_RESET 8'h00
// parallel poll configure field: sense at bit 3, line in bits 2..0
`define PPC_SENSE_BIT 2'd3
`endif

// ===== design/status_poll_pkg.sv
// status poll block: shared types
package status_poll_pkg;
  // serial poll progress
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_ARMED,
    SP_SENT
  } sp_state_t;
  // stored parallel poll assignment
  typedef struct packed {
    logic valid;
    logic sense;
    logic [2:0] line;
  } ppoll_cfg_t;
  // open-drain data bus drive
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } dio_drive_t;
endpackage

// ===== sim/bus_controller_model.sv
// controller model: bus commands, serial and parallel polls, abort
`timescale 1ns/100ps
module bus_controller_model (
  // clock
  input wire logic clk_in,
  // device data lines
  input wire logic [7:0] dio_in,
  input wire logic [7:0] dio_oe_in,
  // command pulses: spe spd unt unl tad lad ppc ppu taken
  output logic [8:0] cmd_out,
  // poll configure field and control lines
  output logic [3:0] ppc_data_out,
  output logic ifc_out,
  output logic ppoll_out
);
  ////////////////////////////////////////////////////////////////////
  // command bit positions
  localparam int SPE = 0, TAD = 4, PPC = 6, TKN = 8;
  // everything idle at time zero
  initial begin
    cmd_out = '0;
    ppc_data_out = '0;
    ifc_out = 1'b0;
    ppoll_out = 1'b0;
  end
  // one-cycle pulse, changed only at falling edges
  task automatic send(input int b);
    @(negedge clk_in);
    cmd_out[b] = 1'b1;
    @(negedge clk_in);
    cmd_out[b] = 1'b0;
  endtask
  // assign line and sense before any parallel poll
  task automatic configure(input logic [3:0] d);
    ppc_data_out = d;
    send(PPC);
  endtask
  // enable, address to talk, take the byte, end with fin
  task automatic serial_poll(input int fin, output logic [7:0] b);
    int n;
    send(SPE);
    send(TAD);
    n = 0;
    // bounded wait: a silent device must not hang the bench
    while (dio_oe_in !== 8'hff && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    b = (n < 20) ? dio_in : 8'hxx;
    send(TKN);
    send(fin);
  endtask
  // hold the poll long enough for the pin synchroniser
  task automatic par_poll(output logic [7:0] oe, output logic [7:0] lv);
    @(negedge clk_in);
    ppoll_out = 1'b1;
    repeat (8) @(negedge clk_in);
    oe = dio_oe_in;
    lv = dio_in;
    ppoll_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  // interface clear held for several cycles
  task automatic abort();
    @(negedge clk_in);
    ifc_out = 1'b1;
    repeat (6) @(negedge clk_in);
    ifc_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
endmodule // bus_controller_model

// ===== sim/gpib_status_poll_logic_tb_top.sv
// testbench: status byte, service request, serial and parallel polls
`timescale 1ns/100ps
module gpib_status_poll_logic_tb_top;
  ////////////////////////////////////////////////////////////////////
  // clock, reset and instrument side stimulus
  logic clk_in = 1'b0, sys_rst_in = 1'b1, standby = 1'b0;
  logic [2:0] inst = 3'h0; // mask write, clear status, output status
  logic [7:0] evt = 8'h00, ext = 8'h00, mdata = 8'h00;
  // partner lines and device outputs
  logic [8:0] cmd;
  logic [3:0] ppd;
  logic ifc, ppl, srq, srq_oe, talker, listener;
  logic [7:0] dio, dio_oe, ext_b, mask_b;
  // scoreboard and scratch
  int bad_count = 0, cmp_count = 0;
  logic [7:0] m, b, x, a, v;
  logic [2:0] l;
  always #20 clk_in = ~clk_in;
  gpib_status_poll_logic uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ifc_pin_in(ifc),
    .ppoll_pin_in(ppl), .standby_switch_position_in(standby),
    .spe_cmd_in(cmd[0]), .spd_cmd_in(cmd[1]), .untalk_cmd_in(cmd[2]),
    .unlisten_cmd_in(cmd[3]), .talk_addr_in(cmd[4]),
    .listen_addr_in(cmd[5]), .ppc_cmd_in(cmd[6]), .ppc_data_in(ppd),
    .ppu_cmd_in(cmd[7]), .byte_taken_in(cmd[8]), .cond_evt_in(evt),
    .ext_cond_in(ext), .mask_wr_in(inst[0]), .mask_data_in(mdata),
    .clear_status_in(inst[1]), .output_status_in(inst[2]),
    .srq_out(srq), .srq_oe_out(srq_oe), .dio_out(dio),
    .dio_oe_out(dio_oe), .talker_out(talker), .listener_out(listener),
    .ext_byte_out(ext_b), .mask_out(mask_b));
  bus_controller_model ctl (
    .clk_in(clk_in), .dio_in(dio), .dio_oe_in(dio_oe), .cmd_out(cmd),
    .ppc_data_out(ppd), .ifc_out(ifc), .ppoll_out(ppl));
  ////////////////////////////////////////////////////////////////////
  // compare one value, count it, report a miss at once
  task automatic chk(input string what, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one-cycle instrument pulses and condition events
  task automatic act(input logic [2:0] c, input logic [7:0] e);
    @(negedge clk_in);
    inst = c;
    evt = e;
    @(negedge clk_in);
    inst = 3'h0;
    evt = 8'h00;
  endtask
  // wait n falling edges
  task automatic tk(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // expected serial poll byte: condition bits plus the summary at 64
  function automatic logic [7:0] poll_expect(input logic [7:0] c,
                                             input logic rq);
    return (c & 8'hbf) | {1'b0, rq, 6'h00};
  endfunction
  // expected extended byte: weights 4 and 128 always read zero
  function automatic logic [7:0] ext_expect(input logic [7:0] raw);
    return raw & 8'h7b;
  endfunction
  // parallel poll: expect the assigned line driven true, or released
  task automatic pp_check(input logic e);
    ctl.par_poll(a, v);
    chk("pp line", e ? 8'h03 : 8'h00, {6'h0, a[l], v[l] & a[l]});
    chk("pp oe", e ? (8'h01 << l) : 8'h00, a);
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'haa9e));
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    tk(1);
    chk("mask reset", 8'h00, mask_b);
    chk("srq reset", 8'h00, {6'h0, srq, srq_oe});
    // settled and end of sweep always enabled, ext change never
    m = (8'($urandom) & 8'hb8) | 8'h18;
    mdata = m;
    act(3'h1, 8'h00);
    tk(1);
    chk("mask", m, mask_b);
    act(3'h0, 8'h01);
    tk(5);
    chk("srq unmasked", 8'h00, {7'h0, srq});
    act(3'h0, 8'h08);
    tk(3);
    chk("srq set", 8'h03, {6'h0, srq, srq_oe});
    act(3'h0, 8'h12); // late: bit4 buffered, bit1 dropped
    ctl.serial_poll(2, b);
    chk("poll 1", poll_expect(8'h09, 1'b1), b);
    tk(1);
    chk("talker after untalk", 8'h00, {7'h0, talker});
    tk(6);
    chk("srq rearmed", 8'h01, {7'h0, srq});
    ctl.serial_poll(1, b);
    chk("poll 2", poll_expect(8'h10, 1'b1), b);
    tk(6);
    chk("srq after disable", 8'h00, {7'h0, srq});
    act(3'h0, 8'h08);
    tk(4);
    act(3'h2, 8'h00);
    tk(6);
    chk("srq after clear", 8'h00, {7'h0, srq});
    ctl.serial_poll(2, b);
    chk("poll 3", poll_expect(8'h00, 1'b0), b);
    // extended byte read only through output status
    repeat (3) begin
      x = 8'($urandom);
      ext = x;
      tk(5);
      act(3'h0, 8'h08);
      tk(4);
      act(3'h4, 8'h00);
      tk(3);
      chk("ext byte", ext_expect(x), ext_b);
      chk("srq after output status", 8'h00, {7'h0, srq});
    end
    ext = ext ^ 8'h01;
    tk(5);
    ctl.serial_poll(2, b);
    chk("poll ext change", poll_expect(8'h04, 1'b0), b);
    // parallel poll, never addressed to talk
    l = 3'($urandom);
    ctl.configure({1'b1, l});
    act(3'h0, 8'h08);
    pp_check(1'b1);
    act(3'h2, 8'h00);
    pp_check(1'b0);
    ctl.configure({1'b0, l});
    pp_check(1'b1);
    ctl.send(7);
    pp_check(1'b0);
    ctl.configure({1'b0, l});
    standby = 1'b1;
    tk(6);
    standby = 1'b0;
    pp_check(1'b0);
    // abort drops both addressed states
    ctl.send(5);
    ctl.send(4);
    tk(2);
    chk("addressed", 8'h03, {6'h0, talker, listener});
    ctl.abort();
    chk("after abort", 8'h00, {6'h0, talker, listener});
    // abort in mid-poll: poll ends, sent byte cleared, unaddressed
    act(3'h0, 8'h08);
    tk(3);
    ctl.send(5);
    ctl.serial_poll(3, b);
    tk(2);
    chk("poll before abort", poll_expect(8'h08, 1'b1), b);
    chk("unlisten", 8'h02, {6'h0, talker, listener});
    chk("srq held without untalk", 8'h01, {7'h0, srq});
    ctl.abort();
    chk("srq after abort", 8'h00, {6'h0, srq, srq_oe});
    chk("dio after abort", 8'h00, dio_oe);
    chk("talker after abort", 8'h00, {7'h0, talker});
    complete_run();
  end
  // watchdog: tests need well under 1000 cycles, allow 5000
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule // gpib_status_poll_logic_tb_top
